// ### logic/pcm_ctrl.sv
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "pcm_cfg.svh"

// Overview of operation
// - Driver on until peak comparator trips, then off for monoflop time.
// - Off time counted against 6-bit monoflop setting from bits 9..4.
// - Peak comparator debounced about one microsecond before ending on phase.
// - Operate only while enable input high; source may PWM it.
// - Jitter bit puts random bits on three low monoflop bits.
// - Random generator steps once per monoflop period.
// - Bit 19 sensor select, bit 18 jitter, bits 17..15 delay.
// - Bits 14..10 temperature code, bits 3..0 peak code.
// - After reset delay state lasts one cycle, as delay code resets to zero before it is read.
// - Fuse use: monoflop off, driver stays on while current watched.
// - Fuse trip latches off until reset or a temperature shutdown followed by its release.
// - Enable low beyond sleep debounce enters sleep.
// - Enable high again leaves sleep after wake-up settling time.
// - Temperature shutdown disabled or on internal or external diode.
// - Driver off when diode reaches programmed threshold.
// - Hysteresis between shutdown and release, automatic return.
module pcm_ctrl #(
    parameter int DLY_UNIT_CYC = `PCM_DLY_UNIT_CYC,
    parameter int SLEEP_CYC = `PCM_SLEEP_CYC,
    parameter int WAKE_CYC = `PCM_WAKE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire pcm_pkg::pcm_bus_req_t bus_req,
    output logic [31:0] rdata,
    // Pins and analog comparators
    input wire logic enable_dim_input,
    input wire logic current_shunt_pin,
    input wire logic temp_trip_int,
    input wire logic temp_release_int,
    input wire logic temp_trip_ext,
    input wire logic temp_release_ext,
    // Outputs
    output logic drive_on,
    output logic sleep_mode,
    output pcm_pkg::pcm_cfg_t cfg_out,
    output logic irq
);
    import pcm_pkg::*;

    // A clock slower than 1 MHz would give a zero window; one cycle is the floor.
    localparam int DEB_CYC = (`PCM_DEB_CYC < 1) ? 1 : `PCM_DEB_CYC;
    localparam int US_CYC = `PCM_US_CYC;

    // ======================================================================
    // Input synchronisers
    // Every pin and comparator is asynchronous to clk, so each passes two flops
    // before any logic looks at it; this costs two cycles of response time.
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_r <= 6'h00;
            sync2_r <= 6'h00;
        end else begin
            sync1_r <= {enable_dim_input, current_shunt_pin, temp_trip_int,
                        temp_release_int, temp_trip_ext, temp_release_ext};
            sync2_r <= sync1_r;
        end
    end
    logic en_s, peak_s, trip_i, rel_i, trip_e, rel_e;
    assign {en_s, peak_s, trip_i, rel_i, trip_e, rel_e} = sync2_r;

    // ======================================================================
    // Registers
    // Writes and reads take one cycle; the port never stalls the master.
    pcm_cfg_t cfg_r;
    pcm_events_t stat_r;
    pcm_events_t ien_r;
    pcm_events_t ev;
    pcm_state_t state_r;
    logic wr_cfg, wr_clr, wr_ien;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction : hit

    assign wr_cfg = bus_req.wr && hit(bus_req.addr, `PCM_REG_CFG);
    assign wr_clr = bus_req.wr && hit(bus_req.addr, `PCM_REG_CLR);
    assign wr_ien = bus_req.wr && hit(bus_req.addr, `PCM_REG_IEN);

    always_ff @(posedge clk) begin
        if (reset) begin
            // Bits above the twenty of the word are ignored so software may write wider.
            cfg_r <= `PCM_CFG_RST;
        end else if (wr_cfg) begin
            cfg_r <= bus_req.wdata[`PCM_CFG_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ien_r <= 4'h0;
        end else if (wr_ien) begin
            ien_r <= bus_req.wdata[3:0];
        end
    end

    // Set wins over a clear arriving in the same cycle.
    always_ff @(posedge clk) begin
        if (reset) begin
            stat_r <= 4'h0;
        end else begin
            stat_r <= (stat_r & ~(wr_clr ? bus_req.wdata[3:0] : 4'h0)) | ev;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= 32'h0000_0000;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                `PCM_REG_CFG: rdata <= {12'h000, cfg_r};
                `PCM_REG_STAT: rdata <= {28'h000_0000, stat_r};
                `PCM_REG_IEN: rdata <= {28'h000_0000, ien_r};
                `PCM_REG_STATE: rdata <= {29'h0000_0000, state_r};
                default: rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    // The interrupt is a level, so software clears the status bit or its enable bit to drop it.
    assign irq = |(stat_r & ien_r);
    assign cfg_out = cfg_r;

    // ======================================================================
    // Peak comparator debounce
    // A trip must persist for the full window so ringing after turn-on
    // cannot end the on phase.
    // The count saturates, so a comparator stuck high keeps the trip asserted.
    logic [7:0] deb_r;
    logic peak_deb;
    always_ff @(posedge clk) begin
        if (reset || !peak_s) begin
            deb_r <= 8'h00;
        end else if (deb_r < 8'(DEB_CYC)) begin
            deb_r <= deb_r + 8'h01;
        end
    end
    assign peak_deb = (deb_r == 8'(DEB_CYC));

    // ======================================================================
    // Temperature shutdown with hysteresis
    // A zero threshold code disables shutdown; the comparators carry the two
    // separate points, so the band itself comes from outside this block.
    logic temp_en, hot_r, trip_sel, rel_sel;
    assign temp_en = (cfg_r.temp_code != 5'h00);
    assign trip_sel = cfg_r.temp_internal ? trip_i : trip_e;
    assign rel_sel = cfg_r.temp_internal ? rel_i : rel_e;
    always_ff @(posedge clk) begin
        if (reset || !temp_en) begin
            hot_r <= 1'b0;
        end else if (trip_sel) begin
            hot_r <= 1'b1;
        end else if (rel_sel) begin
            hot_r <= 1'b0;
        end
    end

    // ======================================================================
    // Jitter generator
    // An eight-bit register is enough here: only three bits are used per period
    // and the pattern need not be long to spread the switching frequency.
    logic [7:0] lfsr_r;
    logic [5:0] mono_eff;
    logic mono_done;
    always_ff @(posedge clk) begin
        if (reset) begin
            lfsr_r <= `PCM_LFSR_SEED;
        end else if (mono_done) begin
            lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
        end
    end
    // Low bits are replaced, so a code with zero upper bits may still jitter.
    assign mono_eff = cfg_r.jitter_en ?
        {cfg_r.mono_code[5:3], lfsr_r[2:0]} : cfg_r.mono_code;

    // ======================================================================
    // Timers
    // The off time is counted in whole microseconds; a prescaler makes the
    // microsecond tick so the monoflop counter stays six bits wide.
    logic [31:0] tmr_r;
    logic [7:0] us_r;
    logic [5:0] mono_cnt_r;
    logic mono_dis;
    assign mono_dis = (cfg_r.mono_code == 6'h00);
    // The off phase ends on the last tick of the final microsecond, so the
    // off time is the effective code times one microsecond.
    assign mono_done = (state_r == PCM_OFF) && (us_r == 8'(US_CYC - 1))
                       && (mono_cnt_r + 6'h01 >= mono_eff);

    logic [31:0] dly_cyc;
    assign dly_cyc = 32'(cfg_r.delay_code) * 32'(DLY_UNIT_CYC);

    // ======================================================================
    // Main state machine
    // Off, idle and the fault states hold the driver low. Enable low in the off
    // phase lets the off time finish first, and the synced enable then keeps the
    // driver from turning on again.
    pcm_state_t state_nxt;
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PCM_DELAY: begin
                // Peak detection is masked until the delay has run out.
                if (tmr_r >= dly_cyc) begin
                    state_nxt = PCM_ON;
                end
            end
            PCM_ON: begin
                if (hot_r) begin
                    state_nxt = PCM_HOT;
                end else if (!en_s) begin
                    state_nxt = PCM_IDLE;
                end else if (peak_deb && mono_dis) begin
                    state_nxt = PCM_FUSED;
                end else if (peak_deb) begin
                    state_nxt = PCM_OFF;
                end
            end
            PCM_OFF: begin
                if (hot_r) begin
                    state_nxt = PCM_HOT;
                end else if (mono_done) begin
                    state_nxt = PCM_ON;
                end
            end
            PCM_FUSED: begin
                // Only a reset or a hot and cool cycle releases a tripped fuse.
                if (hot_r) begin
                    state_nxt = PCM_HOT;
                end
            end
            PCM_HOT: begin
                if (!hot_r) begin
                    state_nxt = PCM_ON;
                end
            end
            PCM_IDLE: begin
                if (en_s) begin
                    state_nxt = PCM_ON;
                end else if (tmr_r >= 32'(SLEEP_CYC)) begin
                    state_nxt = PCM_SLEEP;
                end
            end
            PCM_SLEEP: begin
                if (en_s) begin
                    state_nxt = PCM_WAKE;
                end
            end
            PCM_WAKE: begin
                if (!en_s) begin
                    state_nxt = PCM_SLEEP;
                end else if (tmr_r >= 32'(WAKE_CYC)) begin
                    state_nxt = PCM_ON;
                end
            end
            default: begin
                state_nxt = PCM_DELAY;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= PCM_DELAY;
        end else begin
            state_r <= state_nxt;
        end
    end

    // One shared timer, restarted on every state change.
    // It saturates rather than wraps, so a long stay never fakes a short one.
    always_ff @(posedge clk) begin
        if (reset || state_nxt != state_r) begin
            tmr_r <= 32'h0000_0000;
        end else if (tmr_r != 32'hFFFF_FFFF) begin
            tmr_r <= tmr_r + 32'h0000_0001;
        end
    end

    // The prescaler only runs in the off phase and restarts at its entry.
    always_ff @(posedge clk) begin
        if (reset || state_r != PCM_OFF || us_r == 8'(US_CYC - 1)) begin
            us_r <= 8'h00;
        end else begin
            us_r <= us_r + 8'h01;
        end
    end

    // A wrap of the six-bit count cannot happen: the compare ends the phase first.
    always_ff @(posedge clk) begin
        if (reset || state_r != PCM_OFF) begin
            mono_cnt_r <= 6'h00;
        end else if (us_r == 8'(US_CYC - 1)) begin
            mono_cnt_r <= mono_cnt_r + 6'h01;
        end
    end

    // The driver follows the next state so it switches with the state itself.
    // Gating with the synced enable stops a timed exit from turning the driver
    // on for a cycle while the enable pin is already low.
    logic drive_want;
    assign drive_want = (state_nxt == PCM_ON) || (state_nxt == PCM_DELAY);
    always_ff @(posedge clk) begin
        if (reset) begin
            drive_on <= 1'b0;
        end else begin
            drive_on <= drive_want && en_s;
        end
    end

    // Sleep is flagged from the next state so the output marks the entry cycle.
    always_ff @(posedge clk) begin
        if (reset) begin
            sleep_mode <= 1'b0;
        end else begin
            sleep_mode <= (state_nxt == PCM_SLEEP);
        end
    end

    // ======================================================================
    // Events
    // Each event is a one-cycle pulse on the transition into its state, so a
    // status bit that software has cleared is not set again while it stays there.
    assign ev.peak = (state_r == PCM_ON) && (state_nxt == PCM_OFF);
    assign ev.fused = (state_r == PCM_ON) && (state_nxt == PCM_FUSED);
    assign ev.hot = hot_r && (state_r != PCM_HOT) && (state_nxt == PCM_HOT);
    assign ev.sleep_entered = (state_r != PCM_SLEEP) && (state_nxt == PCM_SLEEP);

endmodule : pcm_ctrl

// ### logic/pcm_cfg.svh
`ifndef PCM_CFG_SVH
`define PCM_CFG_SVH

// ==========================================================================
// Configuration word layout
`define PCM_CFG_W 20
`define PCM_TSEL_BIT 19
`define PCM_JIT_BIT 18
`define PCM_DLY_HI 17
`define PCM_DLY_LO 15
`define PCM_TMP_HI 14
`define PCM_TMP_LO 10
`define PCM_MONO_HI 9
`define PCM_MONO_LO 4
`define PCM_PEAK_HI 3
`define PCM_PEAK_LO 0
`define PCM_CFG_RST 20'h0_0000

// ==========================================================================
// Register map
`define PCM_REG_CFG 4'h0
`define PCM_REG_STAT 4'h1
`define PCM_REG_CLR 4'h2
`define PCM_REG_IEN 4'h3
`define PCM_REG_STATE 4'h4

// ==========================================================================
// Timing
`define PCM_CLK_MHZ 25
`define PCM_DEB_NS 1000
`define PCM_DEB_CYC ((`PCM_DEB_NS * `PCM_CLK_MHZ) / 1000)
`define PCM_US_CYC `PCM_CLK_MHZ
`define PCM_DLY_UNIT_MS 2
`define PCM_DLY_UNIT_CYC (`PCM_DLY_UNIT_MS * 1000 * `PCM_CLK_MHZ)
`define PCM_SLEEP_US 100
`define PCM_SLEEP_CYC (`PCM_SLEEP_US * `PCM_CLK_MHZ)
`define PCM_WAKE_US 50
`define PCM_WAKE_CYC (`PCM_WAKE_US * `PCM_CLK_MHZ)
`define PCM_LFSR_SEED 8'h0001

`endif

// ### logic/pcm_pkg.sv
package pcm_pkg;
    typedef enum logic [2:0] {
        PCM_DELAY, PCM_ON, PCM_OFF, PCM_FUSED, PCM_HOT, PCM_IDLE, PCM_SLEEP, PCM_WAKE
    } pcm_state_t;

    typedef struct packed {
        logic temp_internal;
        logic jitter_en;
        logic [2:0] delay_code;
        logic [4:0] temp_code;
        logic [5:0] mono_code;
        logic [3:0] peak_code;
    } pcm_cfg_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pcm_bus_req_t;

    typedef struct packed {
        logic sleep_entered;
        logic hot;
        logic fused;
        logic peak;
    } pcm_events_t;
endpackage : pcm_pkg

// ### bench/pcm_ctrl_props.sv
`timescale 1ns/1ps
// ==========
// Port checks
module pcm_ctrl_props #(
    parameter int SLEEP_CYC = 2500
) (
    input wire logic clk,
    input wire logic reset,
    input wire pcm_pkg::pcm_bus_req_t bus_req,
    input wire logic [31:0] rdata,
    input wire logic enable_dim_input,
    input wire logic current_shunt_pin,
    input wire logic temp_trip_int,
    input wire logic temp_trip_ext,
    input wire logic drive_on,
    input wire logic sleep_mode,
    input wire pcm_pkg::pcm_cfg_t cfg_out
);
    import pcm_pkg::*;
    logic [31:0] calm_r, shunt_r, low_r, off_r;
    // A fall with a long calm needs a real peak, so each cause is timed separately.
    always_ff @(posedge clk) begin
        if (reset) begin
            calm_r <= '0;
            shunt_r <= '0;
            low_r <= '0;
            off_r <= '0;
        end else begin
            calm_r <= (!enable_dim_input || temp_trip_int || temp_trip_ext) ? '0 : calm_r + 1;
            shunt_r <= current_shunt_pin ? shunt_r + 1 : '0;
            low_r <= enable_dim_input ? '0 : low_r + 1;
            off_r <= drive_on ? '0 : off_r + 1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_fuse_trip;
        $fell(drive_on) && calm_r > 40 && cfg_out.mono_code == 6'h00;
    endsequence
    a_read_idle: assert property (!$past(bus_req.rd) |-> rdata == 32'h0000_0000)
        else $error("read data not idle");
    a_cfg_write: assert property (bus_req.wr && bus_req.addr == 4'h0 |=>
        cfg_out == $past(bus_req.wdata[19:0])) else $error("config write lost");
    a_cfg_read: assert property (bus_req.rd && bus_req.addr == 4'h0 |=>
        rdata == {12'h000, cfg_out}) else $error("config read wrong");
    a_enable_gate: assert property (!enable_dim_input [*4] |=> !drive_on)
        else $error("driver on while disabled");
    a_peak_cause: assert property ($fell(drive_on) |-> calm_r < 40 || shunt_r >= 26)
        else $error("driver off without debounced peak");
    a_off_min: assert property ($rose(drive_on) && calm_r > 40 |-> off_r >= 24)
        else $error("off time too short");
    a_sleep_wait: assert property ($rose(sleep_mode) |-> low_r >= SLEEP_CYC)
        else $error("sleep entered early");
    a_sleep_off: assert property (sleep_mode |-> !drive_on)
        else $error("driver on in sleep");
    a_fuse_hold: assert property (s_fuse_trip |=> !drive_on [*8])
        else $error("fuse did not latch");
endmodule : pcm_ctrl_props

bind pcm_ctrl pcm_ctrl_props #(.SLEEP_CYC(SLEEP_CYC)) chk_u (.clk(clk), .reset(reset),
    .bus_req(bus_req), .rdata(rdata), .enable_dim_input(enable_dim_input),
    .current_shunt_pin(current_shunt_pin), .temp_trip_int(temp_trip_int),
    .temp_trip_ext(temp_trip_ext), .drive_on(drive_on), .sleep_mode(sleep_mode),
    .cfg_out(cfg_out));

// ### bench/pcm_plant.sv
`timescale 1ns/1ps
// ==========
// Coil load, shunt comparator and diode comparators
module pcm_plant #(
    parameter int RAMP = 40
) (
    input wire logic clk,
    input wire logic drive_on,
    input wire logic open_load,
    input wire logic ext_sel,
    input wire logic [7:0] heat,
    output logic current_shunt_pin,
    output logic temp_trip_int,
    output logic temp_release_int,
    output logic temp_trip_ext,
    output logic temp_release_ext
);
    logic [15:0] level_r;
    // The coil discharges fully while off; ringing just after turn-on is short.
    always_ff @(posedge clk) begin
        level_r <= drive_on ? level_r + 16'h0001 : 16'h0000;
        current_shunt_pin <= drive_on && !open_load &&
            (level_r >= RAMP || (level_r > 1 && level_r < 6));
    end
    // Trip and release points differ, giving the hysteresis band.
    always_ff @(posedge clk) begin
        temp_trip_int <= !ext_sel && heat >= 8'h64;
        temp_release_int <= ext_sel || heat < 8'h5A;
        temp_trip_ext <= ext_sel && heat >= 8'h64;
        temp_release_ext <= !ext_sel || heat < 8'h5A;
    end
endmodule : pcm_plant

// ### bench/peak_current_monoflop_ctrl_tb.sv
`timescale 1ns/1ps
// ==========
// Self-checking bench
module peak_current_monoflop_ctrl_tb;
    import pcm_pkg::*;
    logic clk, reset, enable_dim_input, current_shunt_pin, drive_on, sleep_mode, irq;
    logic temp_trip_int, temp_release_int, temp_trip_ext, temp_release_ext;
    logic ext_sel, open_load, rd_d;
    logic [7:0] heat;
    logic [31:0] rdata, lfsr;
    pcm_bus_req_t bus_req;
    pcm_cfg_t cfg_out;
    logic [31:0] exp_q[$];
    int n_errors = 0, checked = 0, n, lo, hi, i;

    pcm_ctrl #(.DLY_UNIT_CYC(20), .SLEEP_CYC(10), .WAKE_CYC(5)) dut_u (.clk(clk),
        .reset(reset), .bus_req(bus_req), .rdata(rdata), .enable_dim_input(enable_dim_input),
        .current_shunt_pin(current_shunt_pin), .temp_trip_int(temp_trip_int),
        .temp_release_int(temp_release_int), .temp_trip_ext(temp_trip_ext),
        .temp_release_ext(temp_release_ext), .drive_on(drive_on), .sleep_mode(sleep_mode),
        .cfg_out(cfg_out), .irq(irq));
    pcm_plant plant_u (.clk(clk), .drive_on(drive_on), .open_load(open_load),
        .ext_sel(ext_sel), .heat(heat), .current_shunt_pin(current_shunt_pin),
        .temp_trip_int(temp_trip_int), .temp_release_int(temp_release_int),
        .temp_trip_ext(temp_trip_ext), .temp_release_ext(temp_release_ext));

    always #20 clk = ~clk;

    task automatic report_and_stop;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        bus_req <= '{a, d, w, !w};
        @(posedge clk);
        bus_req <= '0;
        @(posedge clk);
    endtask : bus

    task automatic rd(input logic [3:0] a, input logic [31:0] want);
        exp_q.push_back(want);
        bus(1'b0, a, 32'h0000_0000);
    endtask : rd

    // Counts the cycles that the driver stays at one level.
    task automatic span(input logic lvl, output int c);
        for (c = 0; c < 4000 && drive_on === lvl; c++) @(posedge clk);
        if (c == 4000) begin
            n_errors++;
            report_and_stop();
        end
    endtask : span

    always @(posedge clk) begin
        rd_d <= bus_req.rd;
        if (rd_d) check(rdata, exp_q.pop_front());
    end

    initial begin
        clk = 0; reset = 1; bus_req = '0; enable_dim_input = 0; heat = 0; ext_sel = 0;
        open_load = 0; lfsr = 32'h8896; rd_d = 0;
        repeat (3) @(posedge clk);
        reset <= 0;
        rd(4'h0, 32'h0000_0000);
        rd(4'hF, 32'h0000_0000);
        bus(1'b1, 4'h0, 32'hFFF8_2427);
        rd(4'h0, 32'h0008_2427);
        bus(1'b1, 4'h3, 32'h0000_0004);
        enable_dim_input <= 1'b1;
        span(0, n);
        span(1, n);
        check(n > 60, 1);
        span(0, n);
        check(n >= 47 && n <= 53, 1);
        bus(1'b1, 4'h0, 32'h000C_2787);
        span(1, n);
        span(0, n);
        lo = 9999;
        hi = 0;
        for (i = 0; i < 6; i++) begin
            span(1, n);
            span(0, n);
            check(n >= 1397 && n <= 1578, 1);
            lo = (n < lo) ? n : lo;
            hi = (n > hi) ? n : hi;
        end
        check(hi > lo, 1);
        bus(1'b1, 4'h0, 32'h0008_2427);
        heat <= 8'h78;
        span(1, n);
        repeat (50) @(posedge clk);
        check(drive_on, 0);
        check(irq, 1);
        rd(4'h4, 32'(PCM_HOT));
        heat <= 8'h5F;
        repeat (50) @(posedge clk);
        check(drive_on, 0);
        heat <= 8'h00;
        span(0, n);
        check(drive_on, 1);
        bus(1'b1, 4'h2, 32'h0000_0004);
        check(irq, 0);
        bus(1'b1, 4'h0, 32'h0000_2427);
        ext_sel <= 1'b1;
        heat <= 8'h78;
        span(1, n);
        repeat (50) @(posedge clk);
        check(drive_on, 0);
        heat <= 8'h00;
        span(0, n);
        ext_sel <= 1'b0;
        bus(1'b1, 4'h0, 32'h0008_0027);
        heat <= 8'h78;
        span(1, n);
        span(0, n);
        check(n >= 47 && n <= 53, 1);
        heat <= 8'h00;
        bus(1'b1, 4'h0, 32'h0008_2427);
        enable_dim_input <= 1'b0;
        for (n = 0; n < 200 && sleep_mode !== 1'b1; n++) @(posedge clk);
        check(sleep_mode, 1);
        if (n == 200) report_and_stop();
        enable_dim_input <= 1'b1;
        span(0, n);
        check(n >= 5, 1);
        for (i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            bus(1'b1, 4'h3, lfsr);
            rd(4'h3, lfsr & 32'h0000_000F);
        end
        bus(1'b1, 4'h0, 32'h0008_2407);
        open_load <= 1'b1;
        repeat (300) @(posedge clk);
        check(drive_on, 1);
        open_load <= 1'b0;
        span(1, n);
        repeat (200) @(posedge clk);
        check(drive_on, 0);
        rd(4'h4, 32'(PCM_FUSED));
        heat <= 8'h78;
        repeat (20) @(posedge clk);
        heat <= 8'h00;
        span(0, n);
        check(drive_on, 1);
        report_and_stop();
    end
endmodule : peak_current_monoflop_ctrl_tb
